/* File: src/airs_top.v */
`include "airs_defs.vh"
`default_nettype none
module airs_top (
	// Clock and reset
	input wire CLK,
	input wire RESET_N,
	// APB slave
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [11:0] PADDR,
	input wire [31:0] PWDATA,
	input wire [3:0] PSTRB,
	output wire PREADY,
	output wire PSLVERR,
	output reg [31:0] PRDATA,
	// Channel select from the converter control register
	input wire [3:0] EXT_CHANNEL_SEL,
	// Input path controls
	output reg [2:0] INPUT_MUX_SEL,
	output reg EXT_CHANNEL_ON,
	output reg [3:0] EXT_CHANNEL_NUM,
	// Reference amplifier controls
	output reg REF_AMP_ENABLE,
	output reg REF_AMP_FROM_BANDGAP,
	output reg AMP_REF_IN_PIN_ON,
	output reg [1:0] REF_AMP_GAIN_SEL,
	// Converter reference controls
	output reg [1:0] REFERENCE_SEL,
	output reg REF_PIN_ON,
	// Bandgap
	output reg BANDGAP_ENABLE,
	// Conversion clock enable
	output reg CONV_CLK_EN
);
	// ==========================================
	// Register storage
	reg [7:0] inclk_ff;
	reg [7:0] ampctl_ff;
	reg [7:0] bgctl_ff;
	reg [7:0] nxt_inclk;
	reg [7:0] nxt_ampctl;
	reg [7:0] nxt_bgctl;
	reg [31:0] nxt_rdata;
	reg addr_ok;
	wire wr_acc;
	wire rd_acc;
	wire div_tick;
	wire [3:0] src;
	wire [3:0] chan_sync;
	reg [3:0] chan_meta_ff;
	reg [3:0] chan_ff;
	// Register select strobes from the address decode
	reg sel_inclk;
	reg sel_ampctl;
	reg sel_bgctl;
	// Write data with the unimplemented bits already dropped
	wire [7:0] wdata_inclk;
	wire [7:0] wdata_ampctl;
	wire [7:0] wdata_bgctl;
	wire wr_low_byte;
	// Named fields of the stored registers
	wire [2:0] div_sel;
	wire amp_en_field;
	wire amp_in_field;
	wire [1:0] ref_field;
	wire [1:0] gain_field;
	wire bg_en_field;
	wire chan_exists;
	// Next values of the registered analog controls
	reg [2:0] nxt_mux_sel;
	reg nxt_ext_on;
	reg [3:0] nxt_ext_num;
	reg nxt_amp_en;
	reg nxt_amp_bg;
	reg nxt_amp_pin_on;
	reg [1:0] nxt_gain;
	reg [1:0] nxt_ref_sel;
	reg nxt_ref_pin_on;
	reg nxt_bg_en;
	reg nxt_conv_en;

	// ==========================================
	// APB decode: zero-wait slave, error on unmapped address
	assign PREADY = 1'b1;
	// Writes land at the access edge; reads are captured one edge earlier
	assign wr_acc = PSEL && PENABLE && PWRITE;
	assign rd_acc = PSEL && !PENABLE && !PWRITE;
	// Error only in access, where the master samples it with PREADY
	assign PSLVERR = PSEL && PENABLE && !addr_ok;

	// Address match; one strobe per register so every path shares one decode
	always @* begin
		sel_inclk = 1'b0;
		sel_ampctl = 1'b0;
		sel_bgctl = 1'b0;
		if (PADDR == `AIRS_ADDR_INCLK) begin
			sel_inclk = 1'b1;
		end else if (PADDR == `AIRS_ADDR_AMPCTL) begin
			sel_ampctl = 1'b1;
		end else if (PADDR == `AIRS_ADDR_BGCTL) begin
			sel_bgctl = 1'b1;
		end
	end

	// Any mapped register; anything else answers with an error
	always @* begin
		addr_ok = sel_inclk || sel_ampctl || sel_bgctl;
	end

	// Unimplemented bits never store, so they always read back as zero
	assign wdata_inclk = PWDATA[7:0] & `AIRS_INCLK_MASK;
	assign wdata_ampctl = PWDATA[7:0] & `AIRS_AMPCTL_MASK;
	assign wdata_bgctl = PWDATA[7:0] & `AIRS_BGCTL_MASK;
	// Registers live in the low byte; other strobes carry nothing
	assign wr_low_byte = wr_acc && PSTRB[0];

	// Write path; a write to an unmapped address changes nothing
	always @* begin
		nxt_inclk = inclk_ff;
		nxt_ampctl = ampctl_ff;
		nxt_bgctl = bgctl_ff;
		if (wr_low_byte) begin
			if (sel_inclk) begin
				nxt_inclk = wdata_inclk;
			end else if (sel_ampctl) begin
				nxt_ampctl = wdata_ampctl;
			end else if (sel_bgctl) begin
				nxt_bgctl = wdata_bgctl;
			end
		end
	end

	// Read data captured in setup so PRDATA comes from a flop in access;
	// unmapped reads return zero alongside the error response
	always @* begin
		nxt_rdata = PRDATA;
		if (rd_acc) begin
			if (sel_inclk) begin
				nxt_rdata = {24'h000000, inclk_ff};
			end else if (sel_ampctl) begin
				nxt_rdata = {24'h000000, ampctl_ff};
			end else if (sel_bgctl) begin
				nxt_rdata = {24'h000000, bgctl_ff};
			end else begin
				nxt_rdata = 32'h00000000;
			end
		end
	end

	// Registers; everything clears at reset
	always @(posedge CLK) begin
		if (!RESET_N) begin
			inclk_ff <= `AIRS_RESET_VAL;
			ampctl_ff <= `AIRS_RESET_VAL;
			bgctl_ff <= `AIRS_RESET_VAL;
			PRDATA <= 32'h00000000;
		end else begin
			inclk_ff <= nxt_inclk;
			ampctl_ff <= nxt_ampctl;
			bgctl_ff <= nxt_bgctl;
			PRDATA <= nxt_rdata;
		end
	end

	// ==========================================
	// Channel field comes from another block's register clock-wise, but it
	// is treated as asynchronous since it may be sourced elsewhere; the
	// cost is two cycles of extra latency on a channel change
	always @(posedge CLK) begin
		if (!RESET_N) begin
			chan_meta_ff <= 4'h0;
			chan_ff <= 4'h0;
		end else begin
			chan_meta_ff <= EXT_CHANNEL_SEL;
			chan_ff <= chan_meta_ff;
		end
	end
	assign chan_sync = chan_ff;
	assign src = inclk_ff[`AIRS_SRC_MSB:`AIRS_SRC_LSB];

	// ==========================================
	// Field taps of the stored registers
	// Divider select goes straight to the counter; a change lands within a period
	assign div_sel = inclk_ff[`AIRS_CKDIV_MSB:`AIRS_CKDIV_LSB];
	assign amp_en_field = ampctl_ff[`AIRS_AMP_EN_BIT];
	assign amp_in_field = ampctl_ff[`AIRS_AMP_IN_BIT];
	assign ref_field = ampctl_ff[`AIRS_REF_MSB:`AIRS_REF_LSB];
	assign gain_field = ampctl_ff[`AIRS_GAIN_MSB:`AIRS_GAIN_LSB];
	assign bg_en_field = bgctl_ff[`AIRS_BG_EN_BIT];
	// Channel codes 12..15 name no pin; the switch stays open so the input floats
	assign chan_exists = (chan_sync[3:2] != 2'h3);

	// ==========================================
	// Input source decode; internal sources switch the external path off
	// so the channel pin is never shorted onto an internal node
	always @* begin
		// Default selects the external input with the channel switch open if a code is ever left out
		nxt_mux_sel = `AIRS_MUX_EXT;
		nxt_ext_on = 1'b0;
		nxt_ext_num = chan_sync;
		case (src)
			`AIRS_SRC_ANALOG_SUPPLY: begin
				nxt_mux_sel = `AIRS_MUX_ANALOG_SUPPLY;
				nxt_ext_on = 1'b0;
			end
			`AIRS_SRC_AVDD2: begin
				nxt_mux_sel = `AIRS_MUX_AVDD2;
				nxt_ext_on = 1'b0;
			end
			`AIRS_SRC_AVDD4: begin
				nxt_mux_sel = `AIRS_MUX_AVDD4;
				nxt_ext_on = 1'b0;
			end
			`AIRS_SRC_VR: begin
				nxt_mux_sel = `AIRS_MUX_VR;
				nxt_ext_on = 1'b0;
			end
			`AIRS_SRC_VR2: begin
				nxt_mux_sel = `AIRS_MUX_VR2;
				nxt_ext_on = 1'b0;
			end
			`AIRS_SRC_VR4: begin
				nxt_mux_sel = `AIRS_MUX_VR4;
				nxt_ext_on = 1'b0;
			end
			4'h8, 4'h9, 4'hA, 4'hB: begin
				nxt_mux_sel = `AIRS_MUX_GND;
				nxt_ext_on = 1'b0;
			end
			default: begin
				// Codes 0, 4 and 12..15 take the external channel
				nxt_mux_sel = `AIRS_MUX_EXT;
				nxt_ext_on = chan_exists;
			end
		endcase
	end

	// Input path outputs; registered so the analog switches see clean levels
	// and never a decode glitch while the source field changes
	always @(posedge CLK) begin
		if (!RESET_N) begin
			INPUT_MUX_SEL <= `AIRS_MUX_EXT;
			EXT_CHANNEL_ON <= 1'b0;
			EXT_CHANNEL_NUM <= 4'h0;
		end else begin
			INPUT_MUX_SEL <= nxt_mux_sel;
			EXT_CHANNEL_ON <= nxt_ext_on;
			EXT_CHANNEL_NUM <= nxt_ext_num;
		end
	end

	// ==========================================
	// Amplifier, reference and bandgap decode
	always @* begin
		// Software keeps this set whenever the amplifier output is used
		nxt_amp_en = amp_en_field;
		nxt_amp_bg = amp_in_field;
		// Pin joined only when chosen; pin-function setup is software's job
		nxt_amp_pin_on = !amp_in_field;
		// Gain steps 1, 1.667, 2.5 and 3.333 for codes 0 to 3
		nxt_gain = gain_field;
		// Codes 1x both take the amplifier output
		nxt_ref_sel = ref_field;
		// Supply or amplifier reference leaves the reference pin open
		if (ref_field == `AIRS_REF_PIN) begin
			nxt_ref_pin_on = 1'b1;
		end else begin
			nxt_ref_pin_on = 1'b0;
		end
		// Start-up settling before bandgap use is left to software
		nxt_bg_en = bg_en_field;
	end

	// Amplifier and reference outputs; all open and off while in reset
	always @(posedge CLK) begin
		if (!RESET_N) begin
			REF_AMP_ENABLE <= 1'b0;
			REF_AMP_FROM_BANDGAP <= 1'b0;
			AMP_REF_IN_PIN_ON <= 1'b0;
			REF_AMP_GAIN_SEL <= 2'h0;
			REFERENCE_SEL <= 2'h0;
			REF_PIN_ON <= 1'b0;
			BANDGAP_ENABLE <= 1'b0;
		end else begin
			REF_AMP_ENABLE <= nxt_amp_en;
			REF_AMP_FROM_BANDGAP <= nxt_amp_bg;
			AMP_REF_IN_PIN_ON <= nxt_amp_pin_on;
			REF_AMP_GAIN_SEL <= nxt_gain;
			REFERENCE_SEL <= nxt_ref_sel;
			REF_PIN_ON <= nxt_ref_pin_on;
			BANDGAP_ENABLE <= nxt_bg_en;
		end
	end

	// ==========================================
	// Conversion clock: enable pulse at CLK / 2**field
	airs_clk_div #(
		.SEL_W(3)
	) u_div (
		.clk(CLK),
		.reset_n(RESET_N),
		.sel(div_sel),
		.tick(div_tick)
	);

	// Conversion clock enable; one flop keeps the pin free of compare glitches
	always @* begin
		nxt_conv_en = div_tick;
	end

	// Registered enable output
	always @(posedge CLK) begin
		if (!RESET_N) begin
			CONV_CLK_EN <= 1'b0;
		end else begin
			CONV_CLK_EN <= nxt_conv_en;
		end
	end
endmodule // airs_top
`default_nettype wire

/* File: common/airs_defs.vh */
`ifndef AIRS_DEFS_VH
`define AIRS_DEFS_VH
// ==========================================
// Register byte addresses on APB
`define AIRS_ADDR_INCLK 12'h000
`define AIRS_ADDR_AMPCTL 12'h004
`define AIRS_ADDR_BGCTL 12'h008
// ==========================================
// Input and clock select fields
`define AIRS_SRC_MSB 7
`define AIRS_SRC_LSB 4
`define AIRS_CKDIV_MSB 2
`define AIRS_CKDIV_LSB 0
// Input source codes
`define AIRS_SRC_EXT0 4'h0
`define AIRS_SRC_ANALOG_SUPPLY 4'h1
`define AIRS_SRC_AVDD2 4'h2
`define AIRS_SRC_AVDD4 4'h3
`define AIRS_SRC_EXT4 4'h4
`define AIRS_SRC_VR 4'h5
`define AIRS_SRC_VR2 4'h6
`define AIRS_SRC_VR4 4'h7
// Analog input mux selects
`define AIRS_MUX_EXT 3'h0
`define AIRS_MUX_ANALOG_SUPPLY 3'h1
`define AIRS_MUX_AVDD2 3'h2
`define AIRS_MUX_AVDD4 3'h3
`define AIRS_MUX_VR 3'h4
`define AIRS_MUX_VR2 3'h5
`define AIRS_MUX_VR4 3'h6
`define AIRS_MUX_GND 3'h7
// ==========================================
// Amplifier control fields
`define AIRS_AMP_EN_BIT 7
`define AIRS_AMP_IN_BIT 4
`define AIRS_REF_MSB 3
`define AIRS_REF_LSB 2
`define AIRS_GAIN_MSB 1
`define AIRS_GAIN_LSB 0
`define AIRS_REF_ANALOG_SUPPLY 2'h0
`define AIRS_REF_PIN 2'h1
// Bandgap control
`define AIRS_BG_EN_BIT 0
// ==========================================
// Writable masks and reset values
`define AIRS_INCLK_MASK 8'hF7
`define AIRS_AMPCTL_MASK 8'h9F
`define AIRS_BGCTL_MASK 8'h01
`define AIRS_RESET_VAL 8'h00
`endif

/* File: src/airs_clk_div.v */
`default_nettype none
// ==========================================
// Power-of-two divider: one-cycle enable every 2**sel clocks
module airs_clk_div #(
	parameter SEL_W = 3
) (
	// Clock and reset
	input wire clk,
	input wire reset_n,
	// Control
	input wire [SEL_W-1:0] sel,
	// Enable out
	output wire tick
);
	localparam CNT_W = (1 << SEL_W) - 1;
	reg [CNT_W-1:0] cnt_ff;
	wire [CNT_W-1:0] mask;
	wire [CNT_W-1:0] nxt_cnt;
	// Mask of the low sel bits; tick when they are all ones
	assign mask = ~({CNT_W{1'b1}} << sel);
	assign tick = ((cnt_ff & mask) == mask);
	assign nxt_cnt = cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
	// Free-running counter, so a divider change takes effect within one period
	always @(posedge clk) begin
		if (!reset_n) begin
			cnt_ff <= {CNT_W{1'b0}};
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end
endmodule // airs_clk_div
`default_nettype wire

/* File: sim/airs_top_sva.sv */
`default_nettype none
// ==========================================
// Port checker for the input and reference select block
module airs_top_sva (
	// Clock and reset
	input wire logic CLK,
	input wire logic RESET_N,
	// APB side
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [3:0] PSTRB,
	// Analog controls
	input wire logic [2:0] INPUT_MUX_SEL,
	input wire logic EXT_CHANNEL_ON,
	input wire logic REF_AMP_FROM_BANDGAP,
	input wire logic AMP_REF_IN_PIN_ON,
	input wire logic [1:0] REF_AMP_GAIN_SEL,
	input wire logic [1:0] REFERENCE_SEL,
	input wire logic REF_PIN_ON,
	input wire logic BANDGAP_ENABLE,
	input wire logic CONV_CLK_EN
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESET_N);
	// Writes landing in each register
	wire wr = PSEL && PENABLE && PWRITE && PSTRB[0];
	wire wr0 = wr && PADDR == 12'h000;
	wire wr1 = wr && PADDR == 12'h004;
	wire wr2 = wr && PADDR == 12'h008;
	wire [3:0] s = PWDATA[7:4];
	wire [2:0] im = s[2:0] - {2'b00, s[2]};
	logic [7:0] gap_ff;
	logic [1:0] np_ff;
	logic [2:0] div_ff;
	// Gap tracker; the first pulses after a write may be short, so three are skipped
	always @(posedge CLK) begin
		if (!RESET_N) begin
			gap_ff <= 8'h00;
			np_ff <= 2'h0;
			div_ff <= 3'h0;
		end else begin
			gap_ff <= CONV_CLK_EN ? 8'h00 : gap_ff + 8'h01;
			if (wr0) begin
				div_ff <= PWDATA[2:0];
				np_ff <= 2'h0;
			end else if (CONV_CLK_EN && np_ff != 2'h3) begin
				np_ff <= np_ff + 2'h1;
			end
		end
	end
	a_int_src_isolates: assert property (INPUT_MUX_SEL != 3'h0 |-> !EXT_CHANNEL_ON)
		else $error("channel switch closed on internal source");
	a_ext_codes_route: assert property (wr0 && (s == 4'h0 || s == 4'h4 || s[3:2] == 2'b11) |-> ##2 INPUT_MUX_SEL == 3'h0)
		else $error("external code not routed");
	a_unused_grounds: assert property (wr0 && s[3:2] == 2'b10 |-> ##2 INPUT_MUX_SEL == 3'h7)
		else $error("unused code not grounded");
	a_int_src_map: assert property (wr0 && !s[3] && s[1:0] != 2'b00 |-> ##2 INPUT_MUX_SEL == $past(im, 2))
		else $error("internal source mapped wrong");
	a_amp_ctl_map: assert property (wr1 |-> ##2 REFERENCE_SEL == $past(PWDATA[3:2], 2)
		&& REF_AMP_GAIN_SEL == $past(PWDATA[1:0], 2) && REF_AMP_FROM_BANDGAP == $past(PWDATA[4], 2))
		else $error("amplifier controls wrong");
	a_bg_drops_pin: assert property ($past(RESET_N) |-> AMP_REF_IN_PIN_ON == !REF_AMP_FROM_BANDGAP)
		else $error("amplifier pin not switched");
	a_ref_pin_only: assert property (REF_PIN_ON |-> REFERENCE_SEL == 2'b01)
		else $error("reference pin left on");
	a_bandgap_bit: assert property (wr2 |-> ##2 BANDGAP_ENABLE == $past(PWDATA[0], 2))
		else $error("bandgap enable wrong");
	a_div_period: assert property (CONV_CLK_EN && np_ff == 2'h3 |-> gap_ff == (8'h01 << div_ff) - 8'h01)
		else $error("conversion clock period wrong");
	a_reset_clears: assert property (disable iff (1'b0) !RESET_N ##1 !RESET_N |->
		INPUT_MUX_SEL == 3'h0 && !BANDGAP_ENABLE && REFERENCE_SEL == 2'h0)
		else $error("reset left controls set");
	c_ground: cover property (wr0 && s[3:2] == 2'b10);
	c_slow_div: cover property (CONV_CLK_EN && np_ff == 2'h3 && div_ff == 3'h7);
	c_bandgap_in: cover property (wr1 && PWDATA[4]);
endmodule // airs_top_sva
bind airs_top airs_top_sva u_sva (.*);
`default_nettype wire

/* File: sim/testbench.sv */
`default_nettype none
// ==========================================
// Testbench
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic CLK = 1'b0, RESET_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
	logic [11:0] PADDR = 12'h000;
	logic [31:0] PWDATA = 32'h0, PRDATA, q, d;
	logic [3:0] PSTRB = 4'hF, EXT_CHANNEL_SEL = 4'h3, EXT_CHANNEL_NUM;
	logic PREADY, PSLVERR, EXT_CHANNEL_ON, REF_AMP_ENABLE, REF_AMP_FROM_BANDGAP, AMP_REF_IN_PIN_ON, slv;
	logic REF_PIN_ON, BANDGAP_ENABLE, CONV_CLK_EN;
	logic [2:0] INPUT_MUX_SEL;
	logic [1:0] REF_AMP_GAIN_SEL, REFERENCE_SEL;
	int err_total = 0, checked = 0, n;
	airs_top u_dut (.*);
	// Clock
	initial begin
		forever #2 CLK = ~CLK;
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// One APB transfer, then an idle cycle so signals never change twice at one edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		n = 0;
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= wd;
		@(posedge CLK);
		PENABLE <= 1'b1;
		do begin
			@(posedge CLK);
			n++;
		end while (PREADY !== 1'b1);
		q = PRDATA;
		slv = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge CLK);
	endtask
	task automatic pwait;
		n = 0;
		do begin
			@(posedge CLK);
			n++;
		end while (CONV_CLK_EN !== 1'b1 && n < 300);
	endtask
	function automatic logic [2:0] emux(input logic [3:0] s);
		if (s[3:2] == 2'b10) return 3'h7;
		if (s == 4'h0 || s == 4'h4 || s[3:2] == 2'b11) return 3'h0;
		return s[2:0] - {2'b00, s[2]};
	endfunction
	task automatic rst_chk;
		RESET_N <= 1'b0;
		repeat (10) @(posedge CLK);
		RESET_N <= 1'b1;
		@(posedge CLK);
		for (int a = 0; a < 3; a++) begin
			apb(1'b0, 12'(a * 4), 32'h0);
			chk(q, 32'h0);
		end
	endtask
	task automatic final_report;
		$display("checked=%0d err_total=%0d", checked, err_total);
		if (err_total == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Watchdog
	initial begin
		repeat (20000) @(posedge CLK);
		err_total++;
		final_report();
	end
	// ==========================================
	// Main sequence
	initial begin
		rst_chk();
		for (int s = 0; s < 16; s++) begin
			apb(1'b1, 12'h000, {24'h0, s[3:0], 4'hD});
			@(posedge CLK);
			chk(INPUT_MUX_SEL, emux(s[3:0]));
			chk(EXT_CHANNEL_ON, emux(s[3:0]) == 3'h0);
			apb(1'b0, 12'h000, 32'h0);
			chk(q, {24'h0, s[3:0], 4'h5});
		end
		EXT_CHANNEL_SEL <= 4'hC;
		repeat (4) @(posedge CLK);
		chk(EXT_CHANNEL_ON, 1'b0);
		EXT_CHANNEL_SEL <= 4'h8;
		repeat (4) @(posedge CLK);
		chk({EXT_CHANNEL_ON, EXT_CHANNEL_NUM}, 5'h18);
		for (int k = 0; k < 8; k++) begin
			apb(1'b1, 12'h000, 32'(k));
			pwait();
			pwait();
			pwait();
			chk(n, 32'h1 << k);
		end
		// Bandgap up and settled before it feeds the amplifier
		apb(1'b1, 12'h008, 32'hFF);
		repeat (20) @(posedge CLK);
		chk(BANDGAP_ENABLE, 1'b1);
		apb(1'b0, 12'h008, 32'h0);
		chk(q, 32'h1);
		// A write without the low byte strobe must leave the register alone
		PSTRB <= 4'hE;
		apb(1'b1, 12'h008, 32'h0);
		PSTRB <= 4'hF;
		apb(1'b0, 12'h008, 32'h0);
		chk(q, 32'h1);
		for (int v = 0; v < 4; v++) begin
			d = {24'h0, v[1], 2'b11, v[1], v[1:0], v[1:0]};
			apb(1'b1, 12'h004, d);
			@(posedge CLK);
			chk({REF_AMP_ENABLE, REF_AMP_FROM_BANDGAP, AMP_REF_IN_PIN_ON, REF_AMP_GAIN_SEL, REFERENCE_SEL, REF_PIN_ON},
				{v[1], v[1], !v[1], v[1:0], v[1:0], v[1:0] == 2'b01});
			apb(1'b0, 12'h004, 32'h0);
			chk(q, d & 32'h9F);
		end
		apb(1'b0, 12'h00C, 32'h0);
		chk(slv, 1'b1);
		chk(q, 32'h0);
		rst_chk();
		final_report();
	end
endmodule // testbench
`default_nettype wire
